// [core/fcq_pkg.sv]
// Shared constants and types of the parallel flash host controller.
// Assumes one 25 MHz clock; the strobe cycle counts below are in cycles of that clock.
package fcq_pkg;
	// Clock period and strobe times, with derived cycle counts (rounded up)
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned T_WE_NS = 40;
	localparam int unsigned T_OE_NS = 80;
	localparam int unsigned WE_CYC_RAW = (T_WE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned OE_CYC_RAW = (T_OE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] WE_CYC = (WE_CYC_RAW < 1) ? 4'h1 : 4'(WE_CYC_RAW);
	localparam logic [3:0] OE_CYC = (OE_CYC_RAW < 1) ? 4'h1 : 4'(OE_CYC_RAW);
	// Flash pin widths and write buffer depth
	localparam int unsigned FL_AW = 22;
	localparam int unsigned FL_DW = 16;
	localparam int unsigned BUF_DEPTH = 16;
	// Register offsets (byte addresses on the APB)
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_ADDR = 8'h04;
	localparam logic [7:0] OFF_WDATA = 8'h08;
	localparam logic [7:0] OFF_COUNT = 8'h0c;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_RDATA = 8'h14;
	localparam logic [7:0] OFF_BUF = 8'h40;
	// Field positions
	localparam int unsigned CTRL_START_BIT = 8;
	localparam int unsigned CTRL_RST_BIT = 16;
	localparam int unsigned STAT_BUSY_BIT = 0;
	localparam int unsigned STAT_ERR_BIT = 1;
	localparam int unsigned STAT_GLK_BIT = 2;
	// Values after reset
	localparam logic RST_HOLD_RESET = 1'b0;
	localparam logic [3:0] RST_COUNT = 4'h0;
	// Unlock cycles and command codes
	localparam logic [21:0] UNLK_ADDR1 = 22'h000555;
	localparam logic [21:0] UNLK_ADDR2 = 22'h0002aa;
	localparam logic [7:0] UNLK_DATA1 = 8'haa;
	localparam logic [7:0] UNLK_DATA2 = 8'h55;
	localparam logic [7:0] CMD_PERM_LOCK = 8'h87;
	localparam logic [7:0] CMD_BUF_LOAD = 8'h25;
	localparam logic [7:0] CMD_BUF_CONFIRM = 8'h29;
	localparam logic [7:0] CMD_PROGRAM = 8'ha0;
	localparam logic [7:0] CMD_PWD_COUNT = 8'h03;
	localparam logic [7:0] CMD_ZERO = 8'h00;
	// Operations that software can start
	typedef enum logic [2:0] {
		OP_READ,
		OP_WRITE,
		OP_UNLOCK,
		OP_PERM_LOCK,
		OP_BUF_PROG,
		OP_PWD_PROG,
		OP_PWD_SUBMIT,
		OP_GLB_READ
	} fcq_op_e;
	// One bus cycle of a sequence
	typedef struct packed {
		logic [21:0] addr;
		logic [15:0] data;
		logic rd;
		logic last;
	} fcq_step_s;
endpackage

// [core/fcq_cyc_if.sv]
// Request and answer between the sequencer and the flash bus cycle engine.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface fcq_cyc_if;
	logic req; // Level: cycle wanted, held until done
	logic [21:0] addr; // Address of the cycle
	logic [15:0] wdata; // Write data
	logic rd; // High for a read cycle
	logic done; // One-cycle pulse: cycle finished
	logic [15:0] rdata; // Read data, valid with done
	modport seq (output req, addr, wdata, rd, input done, rdata);
	modport eng (input req, addr, wdata, rd, output done, rdata);
endinterface
`default_nettype wire

// [core/fcq_cycle.sv]
// Flash bus cycle engine: one read or write cycle on the parallel pins.
// Assumes the flash pins are sampled synchronously to REF_CLK.
`timescale 1ns/10ps
`default_nettype none
module fcq_cycle
(
	input wire logic clk,
	input wire logic rst,
	fcq_cyc_if.eng cyc,
	output logic [21:0] fl_addr,
	output logic [15:0] fl_dq_o,
	input wire logic [15:0] fl_dq_i,
	output logic fl_dq_oe,
	output logic fl_ce_n,
	output logic fl_oe_n,
	output logic fl_we_n
);
	typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} fcq_eng_e;
	fcq_eng_e state_ff; // Engine state
	logic [3:0] cnt_ff; // Strobe length counter
	logic rd_ff; // Latched direction
	logic [21:0] addr_ff; // Latched address
	logic [15:0] wdat_ff; // Latched write data
	logic [15:0] rdat_ff; // Captured read data
	wire strobe_end = (state_ff == E_STROBE) && (cnt_ff == 4'h1); // Last strobe cycle
	// Pin outputs straight from state and latched request
	assign fl_addr = addr_ff;
	assign fl_dq_o = wdat_ff;
	assign fl_dq_oe = (state_ff != E_IDLE) && !rd_ff;
	assign fl_ce_n = (state_ff == E_IDLE);
	assign fl_oe_n = !((state_ff == E_STROBE) && rd_ff);
	assign fl_we_n = !((state_ff == E_STROBE) && !rd_ff);
	assign cyc.done = (state_ff == E_HOLD);
	assign cyc.rdata = rdat_ff;
	// Cycle sequencing: setup, strobe for the timed length, hold
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_ff <= E_IDLE;
			cnt_ff <= 4'h0;
			rd_ff <= 1'b1;
			addr_ff <= '0;
			wdat_ff <= '0;
			rdat_ff <= '0;
		end
		else
		begin
			unique case (state_ff)
				// Latch the request so it stays still for the whole cycle
				E_IDLE:
				begin
					if (cyc.req)
					begin
						addr_ff <= cyc.addr;
						wdat_ff <= cyc.wdata;
						rd_ff <= cyc.rd;
						state_ff <= E_SETUP;
					end
				end
				// Address settles before the strobe falls
				E_SETUP:
				begin
					cnt_ff <= cyc.rd ? fcq_pkg::OE_CYC : fcq_pkg::WE_CYC;
					state_ff <= E_STROBE;
				end
				// Strobe low; read data taken on its last cycle
				E_STROBE:
				begin
					cnt_ff <= cnt_ff - 4'h1;
					if (strobe_end)
					begin
						if (rd_ff)
						begin
							rdat_ff <= fl_dq_i;
						end
						state_ff <= E_HOLD;
					end
				end
				// Strobe high again; answer the sequencer
				E_HOLD:
				begin
					state_ff <= E_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// [core/fcq_host.sv]
// Host controller for a 16-bit asynchronous parallel flash: APB register
// slave that runs single cycles and whole command sequences on the pins.
// Assumes an APB master on REF_CLK and a flash wired to the FL_ pins.
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Permanent lock only after global status reads one
// - Buffer count is words minus one, max 15
// - Buffered words keep first word's upper address
// - Small boot sectors read by own address
// - Password programmed portion by portion, full sequence
module fcq_host
(
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic [21:0] FL_ADDR,
	output logic [15:0] FL_DQ_O,
	input wire logic [15:0] FL_DQ_I,
	output logic FL_DQ_OE,
	output logic FL_CE_N,
	output logic FL_OE_N,
	output logic FL_WE_N,
	output logic FL_RST_N
);
	typedef enum logic [0:0] {S_IDLE, S_RUN} fcq_seq_e;
	fcq_cyc_if cyc (); // Link to the cycle engine
	fcq_seq_e state_ff; // Sequencer state
	fcq_pkg::fcq_op_e op_ff; // Operation being run
	logic [4:0] step_ff; // Bus cycle index within the sequence
	logic [21:0] addr_ff; // Software address register
	logic [15:0] wdata_ff; // Software write data register
	logic [3:0] buffer_word_count_ff; // Words minus one for buffered programming
	logic [15:0] rdata_ff; // Last read data from the flash
	logic hold_rst_ff; // Holds flash in reset while set
	logic err_ff; // Sticky refusal flag
	logic glk_ok_ff; // Global lock status last read as one
	logic [15:0] buf_mem [fcq_pkg::BUF_DEPTH]; // Write buffer and password words
	logic [31:0] prdata_ff; // Read data for the access phase
	// APB decode
	wire setup_ph = PSEL && !PENABLE; // First cycle of a transfer
	wire wr_take = PSEL && PENABLE && PWRITE; // Write takes effect here
	wire hit_buf = (PADDR[7:6] == fcq_pkg::OFF_BUF[7:6]) && (PADDR[1:0] == 2'b00);
	wire hit_reg = (PADDR == fcq_pkg::OFF_CTRL) || (PADDR == fcq_pkg::OFF_ADDR)
		|| (PADDR == fcq_pkg::OFF_WDATA) || (PADDR == fcq_pkg::OFF_COUNT)
		|| (PADDR == fcq_pkg::OFF_STATUS) || (PADDR == fcq_pkg::OFF_RDATA);
	wire hit = hit_buf || hit_reg;
	wire [3:0] buf_sel = PADDR[5:2]; // Buffer word picked by the bus
	wire busy = (state_ff == S_RUN);
	wire wr_ctrl = wr_take && (PADDR == fcq_pkg::OFF_CTRL);
	wire start = wr_ctrl && PWDATA[fcq_pkg::CTRL_START_BIT] && !busy;
	wire [2:0] start_op = PWDATA[2:0];
	wire perm_refused = start && (start_op == 3'(fcq_pkg::OP_PERM_LOCK)) && !glk_ok_ff;
	wire go = start && !perm_refused; // Sequence really begins
	wire refuse = (wr_ctrl && PWDATA[fcq_pkg::CTRL_START_BIT] && busy) || perm_refused;
	wire err_clr = wr_take && (PADDR == fcq_pkg::OFF_STATUS) && PWDATA[fcq_pkg::STAT_ERR_BIT];
	assign PREADY = 1'b1; // Every access completes in its first access cycle
	assign PSLVERR = PSEL && PENABLE && !hit;
	assign PRDATA = prdata_ff;
	assign FL_RST_N = !hold_rst_ff;

	// Command code in the low byte; upper byte driven to zero
	function automatic logic [15:0] cmd(input logic [7:0] code);
		cmd = {8'h00, code};
	endfunction

	// Decode one bus cycle of the running operation
	function automatic fcq_pkg::fcq_step_s step_of(
		input fcq_pkg::fcq_op_e op,
		input logic [4:0] s,
		input logic [21:0] a,
		input logic [15:0] d,
		input logic [3:0] wc,
		input logic [15:0] bw
	);
		fcq_pkg::fcq_step_s r;
		logic [4:0] widx;
		r = '{addr: a, data: d, rd: 1'b0, last: 1'b1};
		widx = s - 5'd4;
		unique case (op)
			// Single cycles, including block and lock status reads
			fcq_pkg::OP_READ, fcq_pkg::OP_GLB_READ:
			begin
				r.rd = 1'b1;
			end
			fcq_pkg::OP_WRITE:
			begin
				r.last = 1'b1;
			end
			// Two unlock cycles, then the command; permanent lock adds 00H
			fcq_pkg::OP_UNLOCK, fcq_pkg::OP_PERM_LOCK:
			begin
				r.last = (op == fcq_pkg::OP_UNLOCK) ? (s == 5'd2) : (s == 5'd3);
				unique case (s[1:0])
					2'd0: r = '{fcq_pkg::UNLK_ADDR1, cmd(fcq_pkg::UNLK_DATA1), 1'b0, 1'b0};
					2'd1: r = '{fcq_pkg::UNLK_ADDR2, cmd(fcq_pkg::UNLK_DATA2), 1'b0, 1'b0};
					2'd2:
					begin
						r.addr = fcq_pkg::UNLK_ADDR1;
						r.data = (op == fcq_pkg::OP_UNLOCK) ? cmd(d[7:0])
							: cmd(fcq_pkg::CMD_PERM_LOCK);
					end
					2'd3: r.data = cmd(fcq_pkg::CMD_ZERO);
				endcase
			end
			// Unlock, load, count, words, confirm
			fcq_pkg::OP_BUF_PROG:
			begin
				r.last = 1'b0;
				if (s == 5'd0)
				begin
					r = '{fcq_pkg::UNLK_ADDR1, cmd(fcq_pkg::UNLK_DATA1), 1'b0, 1'b0};
				end
				else if (s == 5'd1)
				begin
					r = '{fcq_pkg::UNLK_ADDR2, cmd(fcq_pkg::UNLK_DATA2), 1'b0, 1'b0};
				end
				else if (s == 5'd2)
				begin
					r.data = cmd(fcq_pkg::CMD_BUF_LOAD);
				end
				else if (s == 5'd3)
				begin
					r.data = {12'h000, wc};
				end
				else if (widx <= {1'b0, wc})
				begin
					// Low nibble steps, upper address stays that of word zero
					r.addr = {a[21:4], a[3:0] + widx[3:0]};
					r.data = bw;
				end
				else
				begin
					r.data = cmd(fcq_pkg::CMD_BUF_CONFIRM);
					r.last = 1'b1;
				end
			end
			// Program command then one portion, four times over
			fcq_pkg::OP_PWD_PROG:
			begin
				r.last = (s == 5'd7);
				if (!s[0])
				begin
					r.data = cmd(fcq_pkg::CMD_PROGRAM);
				end
				else
				begin
					r.addr = {a[21:2], s[2:1]};
					r.data = bw;
				end
			end
			// Submit: 25H, count 03H, four portions, 29H, all near address zero
			fcq_pkg::OP_PWD_SUBMIT:
			begin
				r.addr = '0;
				r.last = (s == 5'd6);
				if (s == 5'd0)
				begin
					r.data = cmd(fcq_pkg::CMD_BUF_LOAD);
				end
				else if (s == 5'd1)
				begin
					r.data = cmd(fcq_pkg::CMD_PWD_COUNT);
				end
				else if (s == 5'd6)
				begin
					r.data = cmd(fcq_pkg::CMD_BUF_CONFIRM);
				end
				else
				begin
					r.addr = {20'h00000, widx[1:0] + 2'd2};
					r.data = bw;
				end
			end
		endcase
		step_of = r;
	endfunction

	// Buffer word that the current step uses
	wire [4:0] word_idx = (op_ff == fcq_pkg::OP_BUF_PROG) ? (step_ff - 5'd4)
		: (op_ff == fcq_pkg::OP_PWD_PROG) ? {3'b000, step_ff[2:1]}
		: (step_ff - 5'd2);
	wire [15:0] cur_word = buf_mem[word_idx[3:0]];
	wire fcq_pkg::fcq_step_s cur = step_of(op_ff, step_ff, addr_ff, wdata_ff,
		buffer_word_count_ff, cur_word);
	assign cyc.req = busy;
	assign cyc.addr = cur.addr;
	assign cyc.wdata = cur.data;
	assign cyc.rd = cur.rd;
	wire seq_end = cyc.done && cur.last; // Final cycle finished

	// Sequencer: run steps until the last one completes
	always_ff @(posedge REF_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			state_ff <= S_IDLE;
			op_ff <= fcq_pkg::OP_READ;
			step_ff <= 5'd0;
		end
		else if (go)
		begin
			state_ff <= S_RUN;
			op_ff <= fcq_pkg::fcq_op_e'(start_op);
			step_ff <= 5'd0;
		end
		else if (cyc.done)
		begin
			step_ff <= step_ff + 5'd1;
			if (cur.last)
			begin
				state_ff <= S_IDLE;
			end
		end
	end

	// Software registers; busy blocks changes to the operands
	always_ff @(posedge REF_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			addr_ff <= '0;
			wdata_ff <= '0;
			buffer_word_count_ff <= fcq_pkg::RST_COUNT;
			hold_rst_ff <= fcq_pkg::RST_HOLD_RESET;
		end
		else if (wr_take && !busy)
		begin
			if (PADDR == fcq_pkg::OFF_ADDR)
			begin
				addr_ff <= PWDATA[21:0];
			end
			if (PADDR == fcq_pkg::OFF_WDATA)
			begin
				wdata_ff <= PWDATA[15:0];
			end
			if (PADDR == fcq_pkg::OFF_COUNT)
			begin
				buffer_word_count_ff <= PWDATA[3:0];
			end
			if (PADDR == fcq_pkg::OFF_CTRL)
			begin
				hold_rst_ff <= PWDATA[fcq_pkg::CTRL_RST_BIT];
			end
		end
	end

	// Buffer words written by software while idle
	always_ff @(posedge REF_CLK)
	begin
		if (wr_take && hit_buf && !busy)
		begin
			buf_mem[buf_sel] <= PWDATA[15:0];
		end
	end

	// Read data capture, error flag and global lock status
	always_ff @(posedge REF_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			rdata_ff <= '0;
			err_ff <= 1'b0;
			glk_ok_ff <= 1'b0;
		end
		else
		begin
			if (cyc.done && cur.rd)
			begin
				rdata_ff <= cyc.rdata;
			end
			// Set wins over a clear in the same cycle
			err_ff <= refuse || (err_ff && !err_clr);
			if (seq_end && (op_ff == fcq_pkg::OP_GLB_READ))
			begin
				glk_ok_ff <= cyc.rdata[0];
			end
			else if (seq_end && (op_ff == fcq_pkg::OP_PERM_LOCK))
			begin
				glk_ok_ff <= 1'b0;
			end
		end
	end

	// Read mux, captured in the setup cycle
	always_ff @(posedge REF_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			prdata_ff <= '0;
		end
		else if (setup_ph)
		begin
			prdata_ff <= '0;
			if (hit_buf)
			begin
				prdata_ff <= {16'h0000, buf_mem[buf_sel]};
			end
			unique case (PADDR)
				fcq_pkg::OFF_CTRL: prdata_ff <= {15'h0000, hold_rst_ff, 5'h00, op_ff, 8'h00};
				fcq_pkg::OFF_ADDR: prdata_ff <= {10'h000, addr_ff};
				fcq_pkg::OFF_WDATA: prdata_ff <= {16'h0000, wdata_ff};
				fcq_pkg::OFF_COUNT: prdata_ff <= {28'h0000000, buffer_word_count_ff};
				fcq_pkg::OFF_STATUS: prdata_ff <= {29'h00000000, glk_ok_ff, err_ff, busy};
				fcq_pkg::OFF_RDATA: prdata_ff <= {16'h0000, rdata_ff};
				default: ;
			endcase
		end
	end

	// Pin timing engine
	fcq_cycle u_cycle
	(
		.clk(REF_CLK),
		.rst(SYS_RST),
		.cyc(cyc),
		.fl_addr(FL_ADDR),
		.fl_dq_o(FL_DQ_O),
		.fl_dq_i(FL_DQ_I),
		.fl_dq_oe(FL_DQ_OE),
		.fl_ce_n(FL_CE_N),
		.fl_oe_n(FL_OE_N),
		.fl_we_n(FL_WE_N)
	);
endmodule
`default_nettype wire

// [dv/fcq_host_chk.sv]
// Checker: APB answer and flash strobe timing of the host controller.
// Bound onto fcq_host; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module fcq_host_chk
(
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic [7:0] PADDR,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic [21:0] FL_ADDR,
	input wire logic [15:0] FL_DQ_O,
	input wire logic FL_DQ_OE,
	input wire logic FL_CE_N,
	input wire logic FL_OE_N,
	input wire logic FL_WE_N
);
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (SYS_RST);
	// Aligned offsets, split into mapped and unmapped
	wire aligned = (PADDR[1:0] == 2'h0);
	wire mapped = aligned && (PADDR <= 8'h14 || PADDR[7:6] == 2'h1);
	wire acc = PSEL && PENABLE;
	// Address and data held with the chip selected
	sequence s_held;
		$stable(FL_ADDR) && $stable(FL_DQ_O) && !FL_CE_N;
	endsequence
	// Read strobe ends after its second cycle
	sequence s_oe_end;
		!FL_OE_N ##1 FL_OE_N;
	endsequence
	a_ready_always: assert property (PSEL |-> PREADY) else $error("ready low");
	a_err_unmapped: assert property (acc && aligned && !mapped |-> PSLVERR)
		else $error("no error on unmapped offset");
	a_ok_mapped: assert property (acc && mapped |-> !PSLVERR)
		else $error("error on mapped offset");
	a_wr_hold: assert property ($fell(FL_WE_N) |-> s_held ##1 s_held)
		else $error("write cycle not held");
	a_we_width: assert property ($fell(FL_WE_N) |=> FL_WE_N)
		else $error("write strobe width");
	a_oe_width: assert property ($fell(FL_OE_N) |-> ##1 s_oe_end)
		else $error("read strobe width");
	a_strobe_excl: assert property (!(!FL_OE_N && !FL_WE_N))
		else $error("both strobes low");
	a_we_drives: assert property (!FL_WE_N |-> FL_DQ_OE && !FL_CE_N)
		else $error("write strobe without drive");
	a_read_float: assert property (!FL_OE_N |-> !FL_DQ_OE && !FL_CE_N)
		else $error("read while driving");
endmodule
`default_nettype wire

// [dv/fcq_flash_mdl.sv]
// Flash model: logs writes, decodes the permanent lock sequence,
// answers status reads. Assumes held address and data across a strobe.
`timescale 1ns/10ps
`default_nettype none
module fcq_flash_mdl
(
	input wire logic [21:0] FL_ADDR,
	input wire logic [15:0] FL_DQ_O,
	input wire logic FL_CE_N,
	input wire logic FL_OE_N,
	input wire logic FL_WE_N,
	input wire logic FL_RST_N,
	output logic [15:0] FL_DQ_I
);
	logic glk_bit = 1'b1; // Global status bit, one while the flag is clear
	logic perm_used = 1'b0; // Permanent lock has run
	int n = 0; // Writes logged
	logic [37:0] wlog [0:63]; // Logged address and data
	int step = 0; // Position in the lock sequence
	logic [15:0] q = 16'h0000; // Value on the data lines
	logic qry = 1'b0; // Query table mode
	// Query table words; offsets not listed read zero
	function automatic logic [15:0] qword(input logic [7:0] a);
		case (a)
			8'h10: qword = 16'h0051;
			8'h11: qword = 16'h0052;
			8'h12: qword = 16'h0059;
			8'h13: qword = 16'h0002;
			8'h15: qword = 16'h0040;
			8'h1b: qword = 16'h0027;
			8'h1c: qword = 16'h0036;
			8'h1f, 8'h20, 8'h24: qword = 16'h0003;
			8'h21: qword = 16'h0004;
			8'h22: qword = 16'h0005;
			8'h23, 8'h25, 8'h26, 8'h28: qword = 16'h0001;
			8'h27: qword = 16'h0017;
			8'h2a: qword = 16'h0005;
			8'h2c: qword = 16'h0001;
			default: qword = 16'h0000;
		endcase
	endfunction
	wire [10:0] ca = FL_ADDR[10:0]; // Only low address bits decode
	wire [7:0] cd = FL_DQ_O[7:0]; // Only the low byte decodes
	wire [18:0] want = (step == 0) ? {11'h555, 8'haa} :
		(step == 1) ? {11'h2aa, 8'h55} : {11'h555, 8'h87};
	// Log and decode at the closing write strobe edge
	always @(posedge FL_WE_N)
	begin
		if (!FL_CE_N && FL_RST_N)
		begin
			wlog[n] = {FL_ADDR, FL_DQ_O};
			n = n + 1;
			// Query entry on the low address bits; only the F0H exit code leaves it
			if (ca == 11'h055 && cd == 8'h98)
				qry = 1'b1;
			else if (cd == 8'hf0)
				qry = 1'b0;
			if (step == 3)
			begin
				// Final cycle runs only while the global bit reads one
				if (cd == 8'h00 && glk_bit)
					perm_used = 1'b1;
				step = 0;
			end
			else if ({ca, cd} == want)
				step = step + 1;
			else
				step = 0;
		end
	end
	// Drive status or query words while selected and read; flip the lines once released
	always @(FL_CE_N or FL_OE_N or FL_ADDR or glk_bit or qry)
	begin
		if (!FL_CE_N && !FL_OE_N && qry)
			q = qword(FL_ADDR[7:0]);
		else if (!FL_CE_N && !FL_OE_N)
			q = {FL_ADDR[14:0], glk_bit};
		else
			q = ~q;
	end
	assign FL_DQ_I = q;
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Bench of the flash host controller: APB tasks, one task per scenario.
// Assumes the flash model on the pins and the checker bound below.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic ref_clk = 1'b0; // Controller clock
	logic sys_rst = 1'b1; // Controller reset
	logic psel = 1'b0; // APB select
	logic penable = 1'b0; // APB access phase
	logic pwrite = 1'b0; // APB direction
	logic [7:0] paddr = 8'h00; // APB offset
	logic [31:0] pwdata = 32'h0; // APB write data
	logic [31:0] prdata; // APB read data
	logic pready, pslverr; // APB answer
	logic [21:0] fl_addr; // Flash address
	logic [15:0] fl_dq_o, fl_dq_i; // Flash data
	logic fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fl_rst_n; // Flash strobes
	logic [31:0] rd; // Last word read
	logic slv; // Last error answer
	int errors = 0; // Mismatches
	int comparisons = 0; // Comparisons made
	fcq_host dut
	(
		.REF_CLK(ref_clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .FL_ADDR(fl_addr), .FL_DQ_O(fl_dq_o),
		.FL_DQ_I(fl_dq_i), .FL_DQ_OE(fl_dq_oe), .FL_CE_N(fl_ce_n),
		.FL_OE_N(fl_oe_n), .FL_WE_N(fl_we_n), .FL_RST_N(fl_rst_n)
	);
	fcq_flash_mdl mdl
	(
		.FL_ADDR(fl_addr), .FL_DQ_O(fl_dq_o), .FL_CE_N(fl_ce_n), .FL_OE_N(fl_oe_n),
		.FL_WE_N(fl_we_n), .FL_RST_N(fl_rst_n), .FL_DQ_I(fl_dq_i)
	);
	// Clock of 40 ns
	initial
	begin
		forever #20 ref_clk = ~ref_clk;
	end
	// Compare one value
	task chk(input logic [47:0] got, input logic [47:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp)
		begin
			errors = errors + 1;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Compare one logged flash write
	task wl(input int i, input logic [21:0] a, input logic [15:0] d);
		chk({10'h0, mdl.wlog[i]}, {10'h0, a, d});
	endtask
	// One APB transfer; entered and left just after a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1)
			@(posedge ref_clk);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task wreg(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rreg(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	// Poll status until idle; leaves the status word in rd
	task idle;
		int k;
		k = 0;
		rreg(fcq_pkg::OFF_STATUS);
		while (rd[0] !== 1'b0 && k < 400)
		begin
			rreg(fcq_pkg::OFF_STATUS);
			k = k + 1;
		end
		// A sequence that never ends counts as a mismatch
		chk(rd[0], 48'h0);
	endtask
	// One flash read at an address; data left in rd
	task rdw(input logic [21:0] a);
		wreg(fcq_pkg::OFF_ADDR, 32'(a));
		run(fcq_pkg::OP_READ);
		rreg(fcq_pkg::OFF_RDATA);
	endtask
	task start(input fcq_pkg::fcq_op_e op);
		wreg(fcq_pkg::OFF_CTRL, (32'h1 << fcq_pkg::CTRL_START_BIT) | 32'(op));
	endtask
	task run(input fcq_pkg::fcq_op_e op);
		mdl.n = 0;
		start(op);
		idle;
	endtask
	// Reset values, unmapped offset, flash reset pin
	task t_reset;
		chk({fl_ce_n, fl_oe_n, fl_we_n, fl_rst_n}, 48'hf);
		rreg(fcq_pkg::OFF_STATUS);
		chk(rd[1:0], 48'h0);
		rreg(fcq_pkg::OFF_COUNT);
		chk(rd, 48'(fcq_pkg::RST_COUNT));
		rreg(8'h20);
		chk(slv, 48'h1);
		wreg(fcq_pkg::OFF_CTRL, 32'h10000);
		chk(fl_rst_n, 48'h0);
		wreg(fcq_pkg::OFF_CTRL, 32'h0);
		chk(fl_rst_n, 48'h1);
	endtask
	// Single read and write cycles
	task t_single;
		wreg(fcq_pkg::OFF_ADDR, 32'h3f4321);
		run(fcq_pkg::OP_READ);
		rreg(fcq_pkg::OFF_RDATA);
		chk(rd, {15'h4321, 1'b1});
		wreg(fcq_pkg::OFF_WDATA, 32'hbeef);
		run(fcq_pkg::OP_WRITE);
		chk(48'(mdl.n), 48'h1);
		wl(0, 22'h3f4321, 16'hbeef);
	endtask
	// Unlock cycles carry a zero upper byte
	task t_unlock;
		wreg(fcq_pkg::OFF_WDATA, 32'hc3f0);
		run(fcq_pkg::OP_UNLOCK);
		wl(0, 22'h555, 16'h00aa);
		wl(1, 22'h2aa, 16'h0055);
		wl(2, 22'h555, 16'h00f0);
	endtask
	// Permanent lock refused, then run after a global read of one
	task t_perm;
		mdl.glk_bit = 1'b0;
		run(fcq_pkg::OP_GLB_READ);
		chk(rd[2], 48'h0);
		run(fcq_pkg::OP_PERM_LOCK);
		chk({rd[1], 8'(mdl.n)}, {1'b1, 8'h0});
		wreg(fcq_pkg::OFF_STATUS, 32'h2);
		rreg(fcq_pkg::OFF_STATUS);
		chk(rd[1], 48'h0);
		mdl.glk_bit = 1'b1;
		run(fcq_pkg::OP_GLB_READ);
		chk(rd[2], 48'h1);
		wreg(fcq_pkg::OFF_ADDR, 32'h2f0000);
		run(fcq_pkg::OP_PERM_LOCK);
		chk({rd[2:1], 8'(mdl.n), mdl.perm_used}, {2'h0, 8'h4, 1'b1});
		wl(2, 22'h555, 16'h0087);
		wl(3, 22'h2f0000, 16'h0000);
	endtask
	// Largest buffer program; then a start while busy is refused
	task t_buf;
		wreg(fcq_pkg::OFF_COUNT, 32'hf);
		for (int i = 0; i < 16; i++)
			wreg(fcq_pkg::OFF_BUF + 8'(4 * i), 32'h1000 + i);
		wreg(fcq_pkg::OFF_ADDR, 32'h2abcd8);
		run(fcq_pkg::OP_BUF_PROG);
		chk(48'(mdl.n), 48'h15);
		wl(2, 22'h2abcd8, 16'h0025);
		wl(3, 22'h2abcd8, 16'h000f);
		for (int i = 0; i < 16; i++)
			wl(4 + i, {18'h2abcd, 4'(8 + i)}, 16'h1000 + 16'(i));
		wl(20, 22'h2abcd8, 16'h0029);
		start(fcq_pkg::OP_BUF_PROG);
		start(fcq_pkg::OP_READ);
		idle;
		chk(rd[1], 48'h1);
		rreg(fcq_pkg::OFF_CTRL);
		chk(rd[10:8], 48'(fcq_pkg::OP_BUF_PROG));
		wreg(fcq_pkg::OFF_STATUS, 32'h2);
	endtask
	// Password program and submit sequences
	task t_pwd;
		wreg(fcq_pkg::OFF_ADDR, 32'h100);
		run(fcq_pkg::OP_PWD_PROG);
		chk(48'(mdl.n), 48'h8);
		for (int i = 0; i < 4; i++)
		begin
			wl(2 * i, 22'h100, 16'h00a0);
			wl(2 * i + 1, 22'h100 + 22'(i), 16'h1000 + 16'(i));
		end
		run(fcq_pkg::OP_PWD_SUBMIT);
		chk(48'(mdl.n), 48'h7);
		wl(1, 22'h0, 16'h0003);
		for (int i = 0; i < 4; i++)
			wl(2 + i, 22'(i), 16'h1000 + 16'(i));
		wl(6, 22'h0, 16'h0029);
	endtask
	// Query entry with high address and data bits set, table reads, exit
	task t_query;
		wreg(fcq_pkg::OFF_ADDR, 32'h3ff855);
		wreg(fcq_pkg::OFF_WDATA, 32'hab98);
		run(fcq_pkg::OP_WRITE);
		rdw(22'h10);
		chk(rd, 48'h51);
		rdw(22'h15);
		chk(rd, 48'h40);
		rdw(22'h1c);
		chk(rd, 48'h36);
		rdw(22'h1d);
		chk(rd, 48'h0);
		rdw(22'h22);
		chk(rd, 48'h5);
		rdw(22'h27);
		chk(rd, 48'h17);
		rdw(22'h2c);
		chk(rd, 48'h1);
		wreg(fcq_pkg::OFF_ADDR, 32'h0);
		wreg(fcq_pkg::OFF_WDATA, 32'hf0);
		run(fcq_pkg::OP_WRITE);
		rdw(22'h10);
		chk(rd, 48'h21);
	endtask
	// Print counts and verdict, then stop
	task summarize;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Cut a hang short
	initial
	begin
		repeat (30000) @(posedge ref_clk);
		errors = errors + 1;
		summarize;
	end
	// Main sequence
	initial
	begin
		repeat (8) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		t_reset;
		t_single;
		t_unlock;
		t_perm;
		t_buf;
		t_pwd;
		t_query;
		summarize;
	end
endmodule
bind fcq_host fcq_host_chk u_chk
(
	.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
	.PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR), .FL_ADDR(FL_ADDR),
	.FL_DQ_O(FL_DQ_O), .FL_DQ_OE(FL_DQ_OE), .FL_CE_N(FL_CE_N),
	.FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N)
);
`default_nettype wire
